// file: rtl/hpt_pkg.sv
/*
  hpt_pkg: constants and types for the playback trigger and timing offset bank.
  assumes one 125 MHz clock domain for the block and its neighbours.
*/
package hpt_pkg;
  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] ADDR_TRIG = 8'h0c;
  localparam logic [7:0] ADDR_OD_OFS = 8'h0d;
  localparam logic [7:0] ADDR_SP_OFS = 8'h0e;
  localparam logic [7:0] ADDR_SN_OFS = 8'h0f;
  localparam int TRIG_BIT = 0;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam int WAIT_FLAG_BIT = 7;
  // ************************************************************
  // modes
  // ************************************************************
  localparam logic [2:0] MODE_SEQ = 3'h0;
  localparam logic [2:0] MODE_DIAG = 3'h6;
  localparam logic [2:0] MODE_CAL = 3'h7;
  // ************************************************************
  // sequencer and timing
  // ************************************************************
  localparam int SLOT_NUM = 8;
  localparam logic [3:0] SLOT_LAST = 4'h7;
  localparam int WAIT_MS = 10;
  localparam int CLK_KHZ = 125000;
  localparam int WAIT_CYC_DEF = WAIT_MS * CLK_KHZ;
  localparam int TICK_W = 21;
  localparam int LEN_W = 16;
  localparam int OFS_STEP_MS = 5;
  typedef enum {ST_IDLE, ST_FETCH, ST_WAVE, ST_WAIT, ST_ROUT} hpt_state_t;
  typedef enum logic [1:0] {SEG_OD, SEG_POS, SEG_NEG, SEG_ZERO} hpt_seg_t;
endpackage

// file: rtl/hpt_seg_if.sv
/*
  hpt_seg_if: carries one waveform segment and its adjusted length.
  assumes both ends on sys_clk.
*/
`timescale 1ns/1ns
interface hpt_seg_if;
  import hpt_pkg::*;
  logic req;
  logic signed [7:0] amp;
  logic signed [7:0] peak;
  logic [LEN_W-1:0] len;
  logic open_loop;
  logic [7:0] od_ofs;
  logic [7:0] sp_ofs;
  logic [7:0] sn_ofs;
  logic vld;
  hpt_seg_t cls;
  logic [LEN_W-1:0] adj;
  modport src (output req, amp, peak, len, open_loop, od_ofs, sp_ofs, sn_ofs, input vld, cls, adj);
  modport adjr (input req, amp, peak, len, open_loop, od_ofs, sp_ofs, sn_ofs, output vld, cls, adj);
endinterface

// file: rtl/hpt_seg_adj.sv
/*
  hpt_seg_adj: classifies a library waveform segment and applies its time offset.
  assumes lengths and offsets both in 5 ms steps; result one cycle after req.
*/
`timescale 1ns/1ns
module hpt_seg_adj
  import hpt_pkg::*;
(
  input wire logic sys_clk, // clock
  input wire logic sys_rst, // async reset
  hpt_seg_if.adjr s // segment in, adjusted length out
);
  hpt_seg_t cls_d;
  logic [7:0] ofs;
  logic signed [LEN_W+1:0] sum;
  logic vld_q;
  hpt_seg_t cls_q;
  logic [LEN_W-1:0] adj_q;
  logic [LEN_W-1:0] adj_d;

  always_comb begin
    if (s.amp > 8'sh00 && s.amp == s.peak) begin
      cls_d = SEG_OD;
    end else if (s.amp > 8'sh00) begin
      cls_d = SEG_POS;
    end else if (s.amp < 8'sh00) begin
      cls_d = SEG_NEG;
    end else begin
      cls_d = SEG_ZERO;
    end
    case (cls_d)
      SEG_OD: ofs = s.open_loop ? s.od_ofs : 8'h00;
      SEG_POS: ofs = s.sp_ofs;
      SEG_NEG: ofs = s.sn_ofs;
      default: ofs = 8'h00;
    endcase
    // signed offset; a shortened segment never goes below zero
    sum = $signed({2'b00, s.len}) + $signed({{(LEN_W-6){ofs[7]}}, ofs});
    if (sum < 0) begin
      adj_d = '0;
    end else if (sum[LEN_W]) begin
      adj_d = '1;
    end else begin
      adj_d = sum[LEN_W-1:0];
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      vld_q <= 1'b0;
      cls_q <= SEG_ZERO;
      adj_q <= '0;
    end else begin
      vld_q <= s.req;
      cls_q <= s.req ? cls_d : cls_q;
      adj_q <= s.req ? adj_d : adj_q;
    end
  end
  assign s.vld = vld_q;
  assign s.cls = cls_q;
  assign s.adj = adj_q;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  property p_od_closed;
    s.req && !s.open_loop && s.amp > 8'sh00 && s.amp == s.peak |=> s.adj == $past(s.len) && s.cls == SEG_OD;
  endproperty
  a_od_closed: assert property (p_od_closed) else $error("closed loop overdrive changed");
  property p_neg;
    s.req && s.amp < 8'sh00 |=> s.cls == SEG_NEG;
  endproperty
  a_neg: assert property (p_neg) else $error("negative sample misclassified");
  property p_pos;
    s.req && s.amp > 8'sh00 && s.amp != s.peak |=> s.cls == SEG_POS;
  endproperty
  a_pos: assert property (p_pos) else $error("positive sample misclassified");
endmodule

// file: rtl/hpt_trig_bank.sv
/*
  hpt_trig_bank: playback trigger, sequencer walk and waveform time offsets.
  assumes slot data, mode, done strobes and segment requests on sys_clk.
*/
// Operation
// - trigger starts process chosen by mode
// - sequencer mode plays slots from first
// - trigger reads one until sequence finished
// - host clearing trigger aborts sequence
// - calibration or diagnostic mode starts routine
// - overdrive offset signed, 5 ms steps
// - overdrive is samples at waveform maximum
// - overdrive offset only in open loop
// - positive sustain offset signed, 5 ms steps
// - other positive samples are positive sustain
// - negative sustain offset signed, 5 ms steps
// - other negative samples are negative sustain
// - advance slots; stop at zero or eight
// - wait slot idles 10 ms per count
`timescale 1ns/1ns
module hpt_trig_bank
  import hpt_pkg::*;
#(
  parameter int WAIT_CYC = WAIT_CYC_DEF
) (
  input wire logic sys_clk, // clock
  input wire logic sys_rst, // async reset
  input wire logic [7:0] reg_addr, // register address
  input wire logic reg_wr, // write strobe
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_rd, // read strobe
  output logic [7:0] reg_rdata, // read data, cycle after reg_rd
  input wire logic [2:0] mode, // device mode field
  input wire logic open_loop, // open loop operation
  output logic [3:0] slot_idx, // sequencer slot selected
  input wire logic [7:0] slot_data, // contents of selected slot
  output logic wave_start, // start waveform pulse
  output logic [6:0] wave_id, // waveform identifier
  input wire logic wave_done, // waveform finished pulse
  output logic wave_abort, // abort waveform pulse
  output logic routine_start, // start routine pulse
  output logic [2:0] routine_sel, // routine mode
  input wire logic routine_done, // routine finished pulse
  output logic busy, // trigger bit value
  input wire logic seg_req, // segment request
  input wire logic signed [7:0] seg_amp, // segment amplitude
  input wire logic signed [7:0] seg_peak, // waveform maximum
  input wire logic [LEN_W-1:0] seg_len, // length in 5 ms steps
  output logic seg_vld, // adjusted length valid
  output hpt_seg_t seg_cls, // segment class
  output logic [LEN_W-1:0] seg_adj // adjusted length
);
  // ************************************************************
  // register port
  // ************************************************************
  function automatic logic hit(input logic [7:0] a, input logic [7:0] t);
    return a == t;
  endfunction

  hpt_state_t st_q, st_d;
  logic go_q, go_d;
  logic [7:0] od_q, od_d, sp_q, sp_d, sn_q, sn_d;
  logic [7:0] rd_q, rd_d;
  logic [3:0] idx_q, idx_d;
  logic ws_q, ws_d, wa_q, wa_d, rs_q, rs_d;
  logic [6:0] id_q, id_d;
  logic [2:0] rsel_q, rsel_d;
  logic [TICK_W-1:0] tick_q, tick_d;
  logic [6:0] unit_q, unit_d;
  logic wr_trig, set_req, clr_req, known_mode;

  assign wr_trig = reg_wr && hit(reg_addr, ADDR_TRIG);
  assign set_req = wr_trig && reg_wdata[TRIG_BIT];
  assign clr_req = wr_trig && !reg_wdata[TRIG_BIT];
  assign known_mode = mode == MODE_SEQ || mode == MODE_CAL || mode == MODE_DIAG;

  always_comb begin
    od_d = od_q;
    sp_d = sp_q;
    sn_d = sn_q;
    if (reg_wr && hit(reg_addr, ADDR_OD_OFS)) begin
      od_d = reg_wdata;
    end else if (reg_wr && hit(reg_addr, ADDR_SP_OFS)) begin
      sp_d = reg_wdata;
    end else if (reg_wr && hit(reg_addr, ADDR_SN_OFS)) begin
      sn_d = reg_wdata;
    end
    rd_d = 8'h00;
    if (reg_rd && hit(reg_addr, ADDR_TRIG)) begin
      rd_d = {7'h00, go_q};
    end else if (reg_rd && hit(reg_addr, ADDR_OD_OFS)) begin
      rd_d = od_q;
    end else if (reg_rd && hit(reg_addr, ADDR_SP_OFS)) begin
      rd_d = sp_q;
    end else if (reg_rd && hit(reg_addr, ADDR_SN_OFS)) begin
      rd_d = sn_q;
    end
  end

  // ************************************************************
  // trigger and sequencer
  // ************************************************************
  always_comb begin
    st_d = st_q;
    go_d = go_q;
    idx_d = idx_q;
    ws_d = 1'b0;
    wa_d = 1'b0;
    rs_d = 1'b0;
    id_d = id_q;
    rsel_d = rsel_q;
    tick_d = tick_q;
    unit_d = unit_q;
    case (st_q)
      ST_IDLE: begin
        if (set_req && known_mode) begin
          go_d = 1'b1;
          if (mode == MODE_SEQ) begin
            st_d = ST_FETCH;
            idx_d = 4'h0;
          end else begin
            st_d = ST_ROUT;
            rs_d = 1'b1;
            rsel_d = mode;
          end
        end
      end
      ST_FETCH: begin
        if (clr_req) begin
          st_d = ST_IDLE;
          go_d = 1'b0;
        end else if (slot_data == 8'h00) begin
          st_d = ST_IDLE;
          go_d = 1'b0;
        end else if (slot_data[WAIT_FLAG_BIT]) begin
          st_d = ST_WAIT;
          unit_d = slot_data[6:0];
          tick_d = '0;
        end else begin
          st_d = ST_WAVE;
          ws_d = 1'b1;
          id_d = slot_data[6:0];
        end
      end
      ST_WAVE: begin
        if (clr_req) begin
          st_d = ST_IDLE;
          go_d = 1'b0;
          wa_d = 1'b1;
        end else if (wave_done) begin
          if (idx_q == SLOT_LAST) begin
            st_d = ST_IDLE;
            go_d = 1'b0;
          end else begin
            st_d = ST_FETCH;
            idx_d = idx_q + 4'h1;
          end
        end
      end
      ST_WAIT: begin
        // a zero count waits nothing and moves on at once
        if (clr_req) begin
          st_d = ST_IDLE;
          go_d = 1'b0;
        end else if (unit_q == 7'h00) begin
          if (idx_q == SLOT_LAST) begin
            st_d = ST_IDLE;
            go_d = 1'b0;
          end else begin
            st_d = ST_FETCH;
            idx_d = idx_q + 4'h1;
          end
        end else if (tick_q == TICK_W'(WAIT_CYC - 1)) begin
          tick_d = '0;
          unit_d = unit_q - 7'h01;
        end else begin
          tick_d = tick_q + TICK_W'(1);
        end
      end
      ST_ROUT: begin
        // a clear while a routine runs is ignored; the routine ends it
        if (routine_done) begin
          st_d = ST_IDLE;
          go_d = 1'b0;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= ST_IDLE;
      go_q <= REG_RST[TRIG_BIT];
      od_q <= REG_RST;
      sp_q <= REG_RST;
      sn_q <= REG_RST;
      rd_q <= 8'h00;
      idx_q <= 4'h0;
      ws_q <= 1'b0;
      wa_q <= 1'b0;
      rs_q <= 1'b0;
      id_q <= 7'h00;
      rsel_q <= 3'h0;
      tick_q <= '0;
      unit_q <= 7'h00;
    end else begin
      st_q <= st_d;
      go_q <= go_d;
      od_q <= od_d;
      sp_q <= sp_d;
      sn_q <= sn_d;
      rd_q <= rd_d;
      idx_q <= idx_d;
      ws_q <= ws_d;
      wa_q <= wa_d;
      rs_q <= rs_d;
      id_q <= id_d;
      rsel_q <= rsel_d;
      tick_q <= tick_d;
      unit_q <= unit_d;
    end
  end

  assign reg_rdata = rd_q;
  assign slot_idx = idx_q;
  assign wave_start = ws_q;
  assign wave_id = id_q;
  assign wave_abort = wa_q;
  assign routine_start = rs_q;
  assign routine_sel = rsel_q;
  assign busy = go_q;

  // ************************************************************
  // segment offsets
  // ************************************************************
  hpt_seg_if seg ();
  assign seg.req = seg_req;
  assign seg.amp = seg_amp;
  assign seg.peak = seg_peak;
  assign seg.len = seg_len;
  assign seg.open_loop = open_loop;
  assign seg.od_ofs = od_q;
  assign seg.sp_ofs = sp_q;
  assign seg.sn_ofs = sn_q;
  hpt_seg_adj u_adj (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .s(seg)
  );
  assign seg_vld = seg.vld;
  assign seg_cls = seg.cls;
  assign seg_adj = seg.adj;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  property p_seq_start;
    st_q == ST_IDLE && set_req && mode == MODE_SEQ |=> go_q && st_q == ST_FETCH && idx_q == 4'h0;
  endproperty
  a_seq_start: assert property (p_seq_start) else $error("sequence did not start");
  property p_rout_start;
    st_q == ST_IDLE && set_req && (mode == MODE_CAL || mode == MODE_DIAG) |=> rs_q && rsel_q == $past(mode);
  endproperty
  a_rout_start: assert property (p_rout_start) else $error("routine did not start");
  property p_go_hold;
    st_q != ST_IDLE |-> go_q;
  endproperty
  a_go_hold: assert property (p_go_hold) else $error("trigger dropped while busy");
  property p_abort;
    st_q == ST_WAVE && clr_req |=> wa_q && st_q == ST_IDLE && !go_q;
  endproperty
  a_abort: assert property (p_abort) else $error("abort not taken");
  property p_zero_stop;
    st_q == ST_FETCH && !clr_req && slot_data == 8'h00 |=> !go_q && !ws_q;
  endproperty
  a_zero_stop: assert property (p_zero_stop) else $error("zero slot played");
  property p_last;
    st_q == ST_WAVE && !clr_req && wave_done && idx_q == SLOT_LAST |=> st_q == ST_IDLE;
  endproperty
  a_last: assert property (p_last) else $error("ran past last slot");
  property p_wait;
    st_q == ST_FETCH && !clr_req && slot_data[WAIT_FLAG_BIT] |=> st_q == ST_WAIT && !ws_q;
  endproperty
  a_wait: assert property (p_wait) else $error("wait slot played");
  property p_rsv;
    reg_rd && hit(reg_addr, ADDR_TRIG) |=> reg_rdata[7:1] == 7'h00 && reg_rdata[0] == $past(go_q);
  endproperty
  a_rsv: assert property (p_rsv) else $error("trigger readback wrong");
  property p_ignore;
    st_q == ST_IDLE && set_req && !known_mode |=> !go_q;
  endproperty
  a_ignore: assert property (p_ignore) else $error("unknown mode fired");
  c_wave: cover property (ws_q);
  c_abort: cover property (wa_q);
  c_wait: cover property (st_q == ST_WAIT);
  c_rout: cover property (rs_q);
endmodule

// file: verification/hpt_eng.sv
/*
  hpt_eng: slot memory and waveform/routine engine facing the trigger bank.
  assumes sys_clk shared; each done pulse comes dly+1 cycles after its start pulse.
*/
`timescale 1ns/1ns
module hpt_eng
  import hpt_pkg::*;
(
  input wire logic sys_clk, // clock
  input wire logic [3:0] slot_idx, // slot selected
  output logic [7:0] slot_data, // slot byte
  input wire logic wave_start, // start pulse
  input wire logic [6:0] wave_id, // id played
  input wire logic wave_abort, // abort pulse
  output logic wave_done, // wave finished
  input wire logic routine_start, // routine start
  output logic routine_done, // routine finished
  input wire logic [7:0] dly // answer delay, at least 1
);
  logic [7:0] slots [SLOT_NUM];
  logic [6:0] ids [$];
  time t_st [$];
  int cnt = 0;
  int n_abort = 0;
  logic rtn = 1'b0;
  // past slot 7 a non-zero pattern with bit 7 set, so an overrun runs a ninth slot as a wait slot
  assign slot_data = slot_idx[3] ? {4'ha, slot_idx} : slots[slot_idx[2:0]];
  // done outputs settle on the first clock edge, while the bench still holds reset
  always @(posedge sys_clk) begin
    wave_done <= 1'b0;
    routine_done <= 1'b0;
    if (wave_abort) begin
      n_abort <= n_abort + 1;
      cnt <= 0;
    end else if (wave_start || routine_start) begin
      cnt <= dly;
      rtn <= routine_start;
      if (wave_start) begin
        ids.push_back(wave_id);
        t_st.push_back($time);
      end
    end else if (cnt == 1) begin
      cnt <= 0;
      wave_done <= !rtn;
      routine_done <= rtn;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule

// file: verification/test_haptic_playback_trigger_timing.sv
/*
  test_haptic_playback_trigger_timing: self-checking bench for hpt_trig_bank.
  assumes hpt_eng as slot memory and engine; wait unit shortened to WC cycles.
*/
`timescale 1ns/1ns
module test_haptic_playback_trigger_timing;
  import hpt_pkg::*;
  localparam int WC = 8;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, dly = 8'h05, rdata, reg_rdata, slot_data;
  logic reg_wr = 1'b0, reg_rd = 1'b0, open_loop = 1'b0, seg_req = 1'b0;
  logic [2:0] mode = 3'h0, routine_sel;
  logic signed [7:0] seg_amp = 8'h00, seg_peak = 8'h00;
  logic [15:0] seg_len = 16'h0000, seg_adj;
  logic [3:0] slot_idx;
  logic [6:0] wave_id;
  logic wave_start, wave_done, wave_abort, routine_start, routine_done, busy, seg_vld;
  hpt_seg_t seg_cls;
  int mismatches = 0, n_tests = 0, cycles = 0;
  hpt_trig_bank #(.WAIT_CYC(WC)) hpt_trig_bank_i (.sys_clk, .sys_rst, .reg_addr, .reg_wr, .reg_wdata,
    .reg_rd, .reg_rdata, .mode, .open_loop, .slot_idx, .slot_data, .wave_start, .wave_id, .wave_done,
    .wave_abort, .routine_start, .routine_sel, .routine_done, .busy, .seg_req, .seg_amp, .seg_peak,
    .seg_len, .seg_vld, .seg_cls, .seg_adj);
  hpt_eng hpt_eng_i (.sys_clk, .slot_idx, .slot_data, .wave_start, .wave_id, .wave_abort, .wave_done,
    .routine_start, .routine_done, .dly);
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rdata = reg_rdata;
  endtask
  // bounded by the global cycle ceiling
  task automatic wait_idle();
    repeat (2) @(posedge sys_clk);
    while (busy !== 1'b0) @(posedge sys_clk);
    #1;
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_regs();
    logic [7:0] v [4];
    v = '{8'h00, 8'ha5, 8'h80, 8'h7f};
    for (int k = 0; k < 4; k++) begin
      rd(ADDR_TRIG + 8'(k));
      chk("reset value", REG_RST, rdata);
    end
    wr(ADDR_TRIG, 8'hfe);
    rd(ADDR_TRIG);
    chk("trigger reserved bits", 16'h0000, rdata);
    for (int k = 1; k < 4; k++) begin
      wr(ADDR_TRIG + 8'(k), v[k]);
      rd(ADDR_TRIG + 8'(k));
      chk("offset readback", v[k], rdata);
    end
    rd(8'h10);
    chk("unmapped read", 16'h0000, rdata);
    @(posedge sys_clk);
    mode <= 3'h3;
    wr(ADDR_TRIG, 8'h01);
    rd(ADDR_TRIG);
    chk("trigger in unused mode", 16'h0000, rdata);
  endtask
  task automatic t_seq();
    int gap;
    @(posedge sys_clk);
    mode <= MODE_SEQ;
    hpt_eng_i.slots = '{8'h11, 8'h83, 8'h22, 8'h00, 8'h33, 8'h44, 8'h55, 8'h66};
    hpt_eng_i.ids.delete();
    hpt_eng_i.t_st.delete();
    wr(ADDR_TRIG, 8'h01);
    rd(ADDR_TRIG);
    chk("trigger while playing", 16'h0001, rdata);
    wait_idle();
    rd(ADDR_TRIG);
    chk("trigger after sequence", 16'h0000, rdata);
    chk("waves before zero slot", 16'h0002, hpt_eng_i.ids.size());
    chk("first slot id", 16'h0011, hpt_eng_i.ids[0]);
    chk("id after wait slot", 16'h0022, hpt_eng_i.ids[1]);
    // a wait of 3 units between starts; a few cycles of fetch overhead allowed
    gap = int'((hpt_eng_i.t_st[1] - hpt_eng_i.t_st[0]) / 8) - 5 - 3 * WC;
    chk("wait slot length", 16'h0001, gap >= 2 && gap < 8);
    hpt_eng_i.slots = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08};
    hpt_eng_i.ids.delete();
    wr(ADDR_TRIG, 8'h01);
    wait_idle();
    chk("waves of full sequence", 16'h0008, hpt_eng_i.ids.size());
    chk("last slot id", 16'h0008, hpt_eng_i.ids[7]);
  endtask
  task automatic t_abort();
    int a0;
    a0 = hpt_eng_i.n_abort;
    @(posedge sys_clk);
    dly <= 8'h28;
    hpt_eng_i.slots = '{default: 8'h07};
    hpt_eng_i.ids.delete();
    wr(ADDR_TRIG, 8'h01);
    repeat (6) @(posedge sys_clk);
    wr(ADDR_TRIG, 8'h00);
    repeat (60) @(posedge sys_clk);
    #1;
    chk("busy after clear", 16'h0000, busy);
    chk("abort pulses", 16'h0001, hpt_eng_i.n_abort - a0);
    chk("waves after clear", 16'h0001, hpt_eng_i.ids.size());
  endtask
  task automatic t_routine(logic [2:0] m);
    int n;
    @(posedge sys_clk);
    mode <= m;
    dly <= 8'h0a;
    hpt_eng_i.ids.delete();
    wr(ADDR_TRIG, 8'h01);
    n = 0;
    #1;
    while (routine_start !== 1'b1 && n < 20) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk("routine started", 16'h0001, routine_start);
    chk("routine select", m, routine_sel);
    chk("busy in routine", 16'h0001, busy);
    wait_idle();
    chk("no waves in routine", 16'h0000, hpt_eng_i.ids.size());
  endtask
  task automatic seg(logic [7:0] a, logic [7:0] p, logic [15:0] l, logic ol, hpt_seg_t c, logic [15:0] e);
    @(posedge sys_clk);
    seg_req <= 1'b1;
    seg_amp <= a;
    seg_peak <= p;
    seg_len <= l;
    open_loop <= ol;
    @(posedge sys_clk);
    seg_req <= 1'b0;
    #1;
    chk("segment valid", 16'h0001, seg_vld);
    chk("segment class", 16'(c), 16'(seg_cls));
    chk("segment length", e, seg_adj);
  endtask
  task automatic t_seg();
    wr(ADDR_OD_OFS, 8'h02);
    wr(ADDR_SP_OFS, 8'hfe);
    wr(ADDR_SN_OFS, 8'h03);
    seg(8'h64, 8'h64, 16'h000a, 1'b1, SEG_OD, 16'h000c);
    seg(8'h64, 8'h64, 16'h000a, 1'b0, SEG_OD, 16'h000a);
    seg(8'h32, 8'h64, 16'h000a, 1'b1, SEG_POS, 16'h0008);
    seg(8'hce, 8'h64, 16'h000a, 1'b1, SEG_NEG, 16'h000d);
    seg(8'h32, 8'h64, 16'h0001, 1'b1, SEG_POS, 16'h0000);
    seg(8'h00, 8'h64, 16'h000a, 1'b1, SEG_ZERO, 16'h000a);
    wr(ADDR_OD_OFS, 8'hfd);
    seg(8'h64, 8'h64, 16'h000a, 1'b1, SEG_OD, 16'h0007);
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_regs();
    t_seq();
    t_abort();
    t_routine(MODE_DIAG);
    t_routine(MODE_CAL);
    t_seg();
    test_done();
  end
endmodule
